// ===== serial_target_access_map_bench.sv
// self-checking bench for the serial target top
`timescale 1ns/100ps
module serial_target_access_map_bench;
  logic clk;
  logic rst_n;
  logic scl;
  logic hs;
  logic sda_line;
  logic sda_out;
  logic sda_oe_n;
  logic pin;
  logic [9:0] adc_result;
  logic [3:0] adc_channel;
  logic adc_busy;
  logic [7:0] status_in;
  logic [7:0] command_out;
  logic [7:0] config_out;
  logic monitor_pause;
  logic [7:0] q0;
  logic [7:0] q1;
  logic ak;
  int errors;
  int num_checks;
  // pull-up on the wire: low only when someone drives it
  assign sda_line = hs & (sda_oe_n | sda_out);
  stam_top #(.ADC_CONV_CYCLES(300)) uut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .external_addr_pin(pin), .adc_result(adc_result), .adc_channel(adc_channel), .adc_busy(adc_busy),
    .status_in(status_in), .command_out(command_out), .config_out(config_out), .monitor_pause(monitor_pause)
  );
  stam_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(hs));
  ////////////////////////////////////////
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  task results;
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task wb(input logic [7:0] d);
    host.byte_io(d, 1'b1, q1, ak);
    chk({7'h00, ak}, 8'h00);
  endtask
  // a fresh word address every time, stop launches the store
  task wr(input logic [7:0] a, input logic [7:0] w, input logic [7:0] d0, input logic [7:0] d1, input int n);
    host.start();
    wb(a);
    chk({7'h00, monitor_pause}, 8'h01);
    wb(w);
    wb(d0);
    if (n > 1) begin
      wb(d1);
    end
    host.stop();
    chk({7'h00, monitor_pause}, 8'h00);
  endtask
  // dummy write sets the pointer, repeated start, two bytes, host nack
  task rd(input logic [7:0] a, input logic [7:0] w);
    host.start();
    wb(a);
    wb(w);
    host.start();
    wb(a | 8'h01);
    host.byte_io(8'hff, 1'b0, q0, ak);
    host.byte_io(8'hff, 1'b1, q1, ak);
    host.stop();
  endtask
  ////////////////////////////////////////
  task t_reset;
    chk(config_out, 8'h00);
    chk({7'h00, sda_oe_n}, 8'h01);
    chk({7'h00, sda_out}, 8'h00);
    rd(8'h90, 8'h87);
    chk(q0, 8'h00);
    wr(8'h90, 8'h84, 8'h0f, 8'h00, 1);
    chk(config_out, 8'h00);
  endtask
  task t_mem;
    wr(8'h90, 8'h87, 8'h50, 8'h00, 1);
    rd(8'h90, 8'h87);
    chk(q0, 8'h50);
    wr(8'ha0, 8'h1f, 8'hc0, 8'hc1, 2);
    rd(8'ha0, 8'h10);
    chk(q0, 8'hc1);
    rd(8'ha0, 8'h1f);
    chk(q0, 8'hc0);
    wr(8'ha0, 8'hff, 8'h3c, 8'h00, 1);
    rd(8'ha0, 8'hff);
    chk(q0, 8'h3c);
    wr(8'h90, 8'h87, 8'h0a, 8'h00, 1);
    wr(8'ha0, 8'h10, 8'hff, 8'h00, 1);
    rd(8'ha0, 8'h10);
    chk(q0, 8'hc1);
  endtask
  // words above 0fh keep clear of the margining range
  task t_cfg;
    wr(8'h90, 8'h87, 8'h55, 8'h00, 1);
    wr(8'ha2, 8'h20, 8'h5a, 8'h00, 1);
    wr(8'ha0, 8'h20, 8'h96, 8'h00, 1);
    rd(8'ha2, 8'h20);
    chk(q0, 8'h5a);
    rd(8'ha0, 8'h20);
    chk(q0, 8'h96);
    // reads run past the page end on the full pointer
    rd(8'ha0, 8'h1f);
    chk(q1, 8'h96);
  endtask
  task t_cmd;
    wr(8'h90, 8'h81, 8'h9e, 8'h00, 1);
    chk(command_out, 8'h9e);
    rd(8'h90, 8'h80);
    chk(q0, 8'h3b);
    chk(q1, 8'h9e);
  endtask
  task t_adc;
    int polls;
    polls = 0;
    host.start();
    wb(8'h90);
    wb(8'h50);
    chk({4'h0, adc_channel}, 8'h0a);
    chk({7'h00, adc_busy}, 8'h01);
    ak = 1'b1;
    while (ak !== 1'b0 && polls < 20) begin
      host.start();
      host.byte_io(8'h91, 1'b1, q1, ak);
      polls++;
    end
    if (ak !== 1'b0) begin
      errors++;
      results;
    end
    chk({7'h00, polls > 1}, 8'h01);
    chk({7'h00, adc_busy}, 8'h00);
    host.byte_io(8'hff, 1'b0, q0, ak);
    host.byte_io(8'hff, 1'b1, q1, ak);
    host.stop();
    chk(q0, 8'ha2);
    chk(q1, 8'hc7);
  endtask
  task t_addr;
    host.start();
    host.byte_io(8'hc0, 1'b1, q1, ak);
    chk({7'h00, ak}, 8'h01);
    host.stop();
    wr(8'h90, 8'h84, 8'h02, 8'h00, 1);
    chk(config_out, 8'h02);
    pin = 1'b1;
    host.start();
    host.byte_io(8'h90, 1'b1, q1, ak);
    chk({7'h00, ak}, 8'h01);
    host.stop();
    rd(8'h98, 8'h80);
    chk(q0, 8'h3b);
    // alternate memory type, bus bit 1 set, bit 2 back to fixed zero
    wr(8'h98, 8'h84, 8'h05, 8'h00, 1);
    chk(config_out, 8'h05);
    rd(8'hb4, 8'h10);
    chk(q0, 8'hc1);
    host.start();
    host.byte_io(8'ha4, 1'b1, q1, ak);
    chk({7'h00, ak}, 8'h01);
    host.stop();
  endtask
  // a reset in mid-run closes both areas again; stored words survive
  task t_rerst;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk(config_out, 8'h00);
    chk(command_out, 8'h00);
    rd(8'h90, 8'h87);
    chk(q0, 8'h00);
    wr(8'ha0, 8'h10, 8'h77, 8'h00, 1);
    rd(8'ha0, 8'h10);
    chk(q0, 8'hc1);
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    pin = 1'b0;
    adc_result = 10'h2c7;
    status_in = 8'h3b;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_reset;
    t_mem;
    t_cfg;
    t_cmd;
    t_adc;
    t_addr;
    t_rerst;
    results;
  end
endmodule

// ===== stam_conv_timer.sv
// timer that paces one adc conversion
`timescale 1ns/100ps
module stam_conv_timer #(
  parameter int CYCLES = stam_pkg::ADC_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_ni,
  stam_link_if.conv_tmr lk
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
  } stam_tmr_s;

  stam_tmr_s s;
  stam_tmr_s next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (lk.conv_go) begin
      next_s.busy = 1'b1;
      next_s.cnt = CW'(CYCLES - 1);
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lk.conv_busy = s.busy;
  assign lk.conv_done = s.done;
endmodule

// ===== stam_host.sv
// behavioural two-wire host that drives the target's bus lines
`timescale 1ns/100ps
module stam_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  ////////////////////////////////////////
  // four clocks per half period keeps above the three-clock minimum
  task hp;
    repeat (4) @(negedge clk);
  endtask
  task start;
    sda = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda = 1'b0;
    hp;
    scl = 1'b0;
  endtask
  task stop;
    sda = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda = 1'b1;
    hp;
  endtask
  // sda only moves while scl is low; read level taken late in high phase
  task bit_io(input logic b, output logic r);
    sda = b;
    hp;
    scl = 1'b1;
    hp;
    r = sda_line;
    scl = 1'b0;
  endtask
  // msb first, then the acknowledge slot
  task byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ak, a);
  endtask
endmodule

// ===== stam_line_edges.sv
// start, stop and clock-edge detection on the two-wire bus lines
`timescale 1ns/100ps
module stam_line_edges (
  input wire logic clk,
  input wire logic rst_ni,
  input wire logic scl_in,
  input wire logic sda_in,
  stam_link_if.edge_src lk
);
  typedef struct packed {
    logic scl;
    logic sda;
  } stam_edge_s;

  stam_edge_s s;
  stam_edge_s next_s;

  always_comb begin
    next_s.scl = scl_in;
    next_s.sda = sda_in;
  end

  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      s <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // data changing while the clock stays high marks start or stop
  assign lk.start = s.scl & scl_in & s.sda & ~sda_in;
  assign lk.stop = s.scl & scl_in & ~s.sda & sda_in;
  assign lk.rise = ~s.scl & scl_in;
  assign lk.fall = s.scl & ~scl_in;
  assign lk.sda = sda_in;
endmodule

// ===== stam_link_if.sv
// line events and conversion handshake between the block's modules
`timescale 1ns/100ps
interface stam_link_if;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic sda;
  logic conv_go;
  logic conv_busy;
  logic conv_done;
  modport edge_src (output start, stop, rise, fall, sda);
  modport conv_tmr (input conv_go, output conv_busy, conv_done);
endinterface

// ===== stam_pkg.sv
// shared constants and types of the serial target access map
package stam_pkg;
  // device-type codes in the top nibble of the address byte
  localparam logic [3:0] ID_CMD = 4'h9;
  localparam logic [3:0] ID_MEM = 4'ha;
  localparam logic [3:0] ID_MEM_ALT = 4'hb;
  // word addresses in the command/status space
  localparam logic [7:0] STATUS_ADDR = 8'h80;
  localparam logic [7:0] CMD_ADDR = 8'h81;
  localparam logic [7:0] CFG84_ADDR = 8'h84;
  localparam logic [7:0] WP_ADDR = 8'h87;
  // write-protect unlock code, per nibble
  localparam logic [3:0] WP_UNLOCK = 4'h5;
  // reset values
  localparam logic [7:0] WP_RESET = 8'h00;
  localparam logic [7:0] CFG84_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // fields of additional_config_byte
  localparam int CFG_ALT_BIT = 0;
  localparam int CFG_BA2PIN_BIT = 1;
  localparam int CFG_BA1_BIT = 2;
  localparam int CFG_BA0_BIT = 3;
  // word-address byte of an adc command: bit 7 low, channel in 6:3
  localparam int ADC_CMD_BIT = 7;
  localparam int ADC_CH_HI = 6;
  localparam int ADC_CH_LO = 3;
  // storage sizes
  localparam int MEM_WORDS = 256;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // conversion time
  localparam int CLK_MHZ = 100;
  localparam int ADC_CONV_US = 225;
  localparam int ADC_CONV_CYCLES = ADC_CONV_US * CLK_MHZ;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_WORD = 9'h008,
    ST_WACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_DACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } stam_state_e;

  typedef enum logic [2:0] {
    TGT_MEM = 3'h1,
    TGT_CFG = 3'h2,
    TGT_CMD = 3'h4
  } stam_tgt_e;
endpackage

// ===== stam_props.sv
// concurrent checks on the ports of the serial target top
`timescale 1ns/100ps
module stam_props #(
  parameter int ADC_CONV_CYCLES = 22500
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic [3:0] adc_channel,
  input wire logic adc_busy,
  input wire logic [7:0] config_out,
  input wire logic monitor_pause
);
  logic [15:0] busy_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // a counter instead of a long repetition keeps the tools fast
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= adc_busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////
  AST_RESET_STATE: assert property ($rose(rst_n) |->
    sda_oe_n && !monitor_pause && !adc_busy && config_out == 8'h00) else $error("outputs left reset state early");
  AST_DRIVE_SCL_LOW: assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("sda driven outside scl low");
  AST_PAUSE_AT_ACK: assert property ($rose(monitor_pause) |-> !sda_oe_n && !$past(scl_in))
    else $error("pause began without address ack");
  AST_PAUSE_TO_STOP: assert property ($fell(monitor_pause) |->
    $past(scl_in) && $past(sda_in) && !$past(sda_in, 2)) else $error("pause ended without stop");
  AST_NO_ACK_BUSY: assert property (adc_busy |-> !$fell(sda_oe_n))
    else $error("ack given during conversion");
  AST_CONV_START: assert property ($rose(adc_busy) |-> !sda_oe_n && $past(!sda_oe_n))
    else $error("conversion not started at word ack");
  AST_CONV_LEN: assert property ($fell(adc_busy) |-> busy_cnt == 16'(ADC_CONV_CYCLES))
    else $error("conversion length wrong");
  AST_CHAN_AT_ACK: assert property (!$stable(adc_channel) |-> !sda_oe_n)
    else $error("channel changed outside ack");
  AST_CFG_IN_TXN: assert property (!$stable(config_out) |-> $past(monitor_pause))
    else $error("config byte changed outside a transfer");
endmodule

bind stam_top stam_props #(.ADC_CONV_CYCLES(ADC_CONV_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .adc_channel(adc_channel), .adc_busy(adc_busy), .config_out(config_out), .monitor_pause(monitor_pause)
);

// ===== stam_top.sv
// two-wire serial target: address decode, protection, storage, adc read
//
// Functional notes
// - after power-up memory and configuration writes are blocked; protection is volatile.
// - write-protect register sits at word 87h under device type 1001b.
// - upper protect nibble equal to 0101b opens the general memory.
// - lower protect nibble equal to 0101b opens the configuration registers.
// - any other nibble value closes the matching area again.
// - configuration registers answer on the memory type code only with bus bit 0 high.
// - general memory answers on the memory type code only with bus bit 0 low.
// - general memory holds 2k bits reachable over the serial bus.
// - bus bits 1:0 programmable; bit 2 is fixed zero or follows the pin.
// - one extra configuration byte sits at word 84h under type 1001b.
// - command/status space answers on type 1001b matching all three bus bits.
// - adc read starts with a dummy write; channel in word bits 6:3.
// - conversion starts at the word acknowledge and lasts 225 us.
// - no address byte is acknowledged while a conversion runs; host polls.
// - after conversion, read returns 10-bit result with 4-bit channel echo.
// - address byte is type code, three bus bits, then direction bit.
// - up to 16 bytes per page write; stop launches the store.
// - monitoring pauses from address acknowledge until a valid stop.
`timescale 1ns/100ps
module stam_top #(
  parameter int ADC_CONV_CYCLES = stam_pkg::ADC_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic external_addr_pin,
  input wire logic [9:0] adc_result,
  output logic [3:0] adc_channel,
  output logic adc_busy,
  input wire logic [7:0] status_in,
  output logic [7:0] command_out,
  output logic [7:0] config_out,
  output logic monitor_pause
);
  typedef struct packed {
    stam_pkg::stam_state_e st;
    stam_pkg::stam_tgt_e tgt;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] wp;
    logic [7:0] cfg84;
    logic [7:0] cmd;
    logic pause;
    logic oe_n;
    logic [3:0] adc_ch;
    logic [9:0] adc_res;
    logic adc_half;
    logic go;
    logic [stam_pkg::PAGE_BYTES-1:0] pg_valid;
    logic [3:0] pg_base;
    logic pg_cfg;
  } stam_top_s;

  localparam stam_top_s S_RESET = '{
    st: stam_pkg::ST_IDLE,
    tgt: stam_pkg::TGT_MEM,
    oe_n: 1'b1,
    wp: stam_pkg::WP_RESET,
    cfg84: stam_pkg::CFG84_RESET,
    cmd: stam_pkg::CMD_RESET,
    default: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync;
  logic rst_ni;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_ni = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  stam_link_if lk ();

  stam_line_edges u_edges (
    .clk(clk),
    .rst_ni(rst_ni),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .lk(lk.edge_src)
  );

  stam_conv_timer #(.CYCLES(ADC_CONV_CYCLES)) u_timer (
    .clk(clk),
    .rst_ni(rst_ni),
    .lk(lk.conv_tmr)
  );

  // bus bits compared only where care is set
  function automatic logic ba_match(input logic [2:0] rx, input logic [2:0] own, input logic [2:0] care);
    ba_match = ((rx ^ own) & care) == 3'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage

  stam_top_s s;
  stam_top_s next_s;

  logic [7:0] mem_arr [stam_pkg::MEM_WORDS];
  logic [7:0] cfg_arr [stam_pkg::MEM_WORDS];
  logic [7:0] pg_data [stam_pkg::PAGE_BYTES];

  logic pg_we;
  logic [3:0] pg_idx;
  logic [7:0] pg_wd;
  logic commit;

  // the staged page goes to the array only at stop, as a store would
  always_ff @(posedge clk) begin
    if (pg_we) begin
      pg_data[pg_idx] <= pg_wd;
    end
    if (commit) begin
      for (int i = 0; i < stam_pkg::PAGE_BYTES; i++) begin
        if (s.pg_valid[i]) begin
          if (s.pg_cfg) begin
            cfg_arr[{s.pg_base, 4'(i)}] <= pg_data[i];
          end else begin
            mem_arr[{s.pg_base, 4'(i)}] <= pg_data[i];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic mem_open;
  logic cfg_open;
  logic own_ba2;
  logic [3:0] rx_id;
  logic [2:0] rx_ba;
  logic mem_hit;
  logic cfg_hit;
  logic cmd_hit;
  logic [7:0] rdb;

  assign mem_open = s.wp[7:4] == stam_pkg::WP_UNLOCK;
  assign cfg_open = s.wp[3:0] == stam_pkg::WP_UNLOCK;
  assign own_ba2 = s.cfg84[stam_pkg::CFG_BA2PIN_BIT] & external_addr_pin;
  assign rx_id = s.sh[7:4];
  assign rx_ba = s.sh[3:1];

  always_comb begin
    logic space;
    logic [2:0] own;
    space = rx_id == (s.cfg84[stam_pkg::CFG_ALT_BIT] ? stam_pkg::ID_MEM_ALT : stam_pkg::ID_MEM);
    own = {own_ba2, s.cfg84[stam_pkg::CFG_BA1_BIT], s.cfg84[stam_pkg::CFG_BA0_BIT]};
    mem_hit = space & ba_match(rx_ba, own, 3'h6) & ~rx_ba[0];
    cfg_hit = space & ba_match(rx_ba, own, 3'h6) & rx_ba[0];
    cmd_hit = (rx_id == stam_pkg::ID_CMD) & ba_match(rx_ba, own, 3'h7);
  end

  // byte returned at the pointer of the current read target
  always_comb begin
    rdb = 8'h00;
    unique case (s.tgt)
      stam_pkg::TGT_MEM: rdb = mem_arr[s.ptr];
      stam_pkg::TGT_CFG: rdb = cfg_arr[s.ptr];
      stam_pkg::TGT_CMD: begin
        if (!s.ptr[stam_pkg::ADC_CMD_BIT]) begin
          rdb = s.adc_half ? s.adc_res[7:0] : {s.adc_ch, 2'h0, s.adc_res[9:8]};
        end else begin
          unique case (s.ptr)
            stam_pkg::WP_ADDR: rdb = s.wp;
            stam_pkg::CFG84_ADDR: rdb = s.cfg84;
            stam_pkg::STATUS_ADDR: rdb = status_in;
            stam_pkg::CMD_ADDR: rdb = s.cmd;
            default: rdb = 8'h00;
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  always_comb begin
    next_s = s;
    next_s.go = 1'b0;
    pg_we = 1'b0;
    pg_idx = s.ptr[3:0];
    pg_wd = s.sh;
    commit = 1'b0;
    if (lk.conv_done) begin
      next_s.adc_res = adc_result;
    end
    if (lk.stop) begin
      next_s.st = stam_pkg::ST_IDLE;
      next_s.oe_n = 1'b1;
      next_s.pause = 1'b0;
      if (|s.pg_valid) begin
        commit = 1'b1;
        next_s.pg_valid = '0;
      end
    end else if (lk.start) begin
      next_s.st = stam_pkg::ST_ADDR;
      next_s.cnt = 4'h0;
      next_s.oe_n = 1'b1;
    end else if (lk.rise) begin
      if (s.st == stam_pkg::ST_RACK) begin
        next_s.nack = lk.sda;
      end else if (s.st inside {stam_pkg::ST_ADDR, stam_pkg::ST_WORD, stam_pkg::ST_WDATA, stam_pkg::ST_RDATA}) begin
        next_s.sh = {s.sh[6:0], lk.sda};
        next_s.cnt = s.cnt + 4'h1;
      end
    end else if (lk.fall) begin
      unique case (s.st)
        stam_pkg::ST_IDLE: begin
        end
        stam_pkg::ST_ADDR: begin
          if (s.cnt == stam_pkg::BITS_PER_BYTE) begin
            next_s.cnt = 4'h0;
            // a running conversion silences every address byte
            if ((mem_hit | cfg_hit | cmd_hit) & ~lk.conv_busy) begin
              next_s.oe_n = 1'b0;
              next_s.pause = 1'b1;
              next_s.rw = s.sh[0];
              next_s.tgt = cmd_hit ? stam_pkg::TGT_CMD : (cfg_hit ? stam_pkg::TGT_CFG : stam_pkg::TGT_MEM);
              next_s.st = stam_pkg::ST_AACK;
            end else begin
              next_s.st = stam_pkg::ST_IDLE;
            end
          end
        end
        stam_pkg::ST_AACK: begin
          if (s.rw) begin
            // reads continue from the pointer of the preceding dummy write
            next_s.tx = rdb;
            next_s.oe_n = rdb[7];
            next_s.st = stam_pkg::ST_RDATA;
            if (s.tgt == stam_pkg::TGT_CMD && !s.ptr[stam_pkg::ADC_CMD_BIT]) begin
              next_s.adc_half = ~s.adc_half;
            end else begin
              next_s.ptr = s.ptr + 8'h01;
            end
          end else begin
            next_s.oe_n = 1'b1;
            next_s.st = stam_pkg::ST_WORD;
          end
        end
        stam_pkg::ST_WORD: begin
          if (s.cnt == stam_pkg::BITS_PER_BYTE) begin
            next_s.cnt = 4'h0;
            next_s.ptr = s.sh;
            next_s.adc_half = 1'b0;
            next_s.oe_n = 1'b0;
            next_s.st = stam_pkg::ST_WACK;
            if (s.tgt == stam_pkg::TGT_CMD && !s.sh[stam_pkg::ADC_CMD_BIT]) begin
              next_s.go = 1'b1;
              next_s.adc_ch = s.sh[stam_pkg::ADC_CH_HI:stam_pkg::ADC_CH_LO];
            end
          end
        end
        stam_pkg::ST_WACK: begin
          next_s.oe_n = 1'b1;
          next_s.st = stam_pkg::ST_WDATA;
        end
        stam_pkg::ST_WDATA: begin
          if (s.cnt == stam_pkg::BITS_PER_BYTE) begin
            next_s.cnt = 4'h0;
            next_s.oe_n = 1'b0;
            next_s.st = stam_pkg::ST_DACK;
            if (s.tgt == stam_pkg::TGT_CMD) begin
              next_s.ptr = s.ptr + 8'h01;
              unique case (s.ptr)
                stam_pkg::WP_ADDR: next_s.wp = s.sh;
                stam_pkg::CFG84_ADDR: begin
                  if (cfg_open) begin
                    next_s.cfg84 = s.sh;
                  end
                end
                stam_pkg::CMD_ADDR: next_s.cmd = s.sh;
                default: begin
                end
              endcase
            end else begin
              // page offset wraps; a page change without stop is not supported
              next_s.ptr = {s.ptr[7:4], s.ptr[3:0] + 4'h1};
              if (s.tgt == stam_pkg::TGT_MEM ? mem_open : cfg_open) begin
                pg_we = 1'b1;
                next_s.pg_valid[s.ptr[3:0]] = 1'b1;
                next_s.pg_base = s.ptr[7:4];
                next_s.pg_cfg = s.tgt == stam_pkg::TGT_CFG;
              end
            end
          end
        end
        stam_pkg::ST_DACK: begin
          next_s.oe_n = 1'b1;
          next_s.st = stam_pkg::ST_WDATA;
        end
        stam_pkg::ST_RDATA: begin
          if (s.cnt == stam_pkg::BITS_PER_BYTE) begin
            next_s.cnt = 4'h0;
            next_s.oe_n = 1'b1;
            next_s.st = stam_pkg::ST_RACK;
          end else begin
            next_s.tx = {s.tx[6:0], 1'b0};
            next_s.oe_n = s.tx[6];
          end
        end
        stam_pkg::ST_RACK: begin
          if (s.nack) begin
            next_s.st = stam_pkg::ST_IDLE;
          end else begin
            next_s.tx = rdb;
            next_s.oe_n = rdb[7];
            next_s.st = stam_pkg::ST_RDATA;
            if (s.tgt == stam_pkg::TGT_CMD && !s.ptr[stam_pkg::ADC_CMD_BIT]) begin
              next_s.adc_half = ~s.adc_half;
            end else begin
              next_s.ptr = s.ptr + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // protection and all control state return to the closed setting on reset
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      s <= S_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign lk.conv_go = s.go;
  // open drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_n = s.oe_n;
  assign adc_channel = s.adc_ch;
  assign adc_busy = lk.conv_busy;
  assign command_out = s.cmd;
  assign config_out = s.cfg84;
  assign monitor_pause = s.pause;
endmodule
